// ### rtl/qsrpi_pkg.sv
// Shared constants, pin bundle and write record of the burst SRAM port interface.
package qsrpi_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widest configuration, which sizes every carrier.
  localparam int MAX_DW = 36;
  localparam int MAX_AW = 21;

  // Supported word widths and the address width each needs.
  localparam int DW_X8 = 8;
  localparam int DW_X9 = 9;
  localparam int DW_X18 = 18;
  localparam int DW_X36 = 36;
  localparam int AW_X8 = 21;
  localparam int AW_X18 = 20;
  localparam int AW_X36 = 19;

  // Mask lane layout: two nibble masks on the narrowest part, 9-bit lanes elsewhere.
  localparam int NIB_W = 4;
  localparam int NIB_MASKS = 2;
  localparam int LANE_W = 9;
  localparam int BYTE_MASKS = 4;

  // Words per burst and the FIFO that decouples write capture from the arrays.
  localparam int BURST_LEN = 2;
  localparam int WR_FIFO_DEPTH = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Every pin that enters from the memory controller, all outside our clock domain.
  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic single_clk_mode;
    logic read_port_sel_n;
    logic write_port_sel_n;
    logic [MAX_AW-1:0] addr;
    logic [MAX_DW-1:0] data;
    logic [NIB_MASKS-1:0] nibble_wr_mask_n;
    logic [BYTE_MASKS-1:0] byte_wr_mask_n;
  } qsrpi_pins_t;

  // One complete write burst with its per-bit enables.
  typedef struct packed {
    logic [MAX_AW-1:0] addr;
    logic [MAX_DW-1:0] d0;
    logic [MAX_DW-1:0] d1;
    logic [MAX_DW-1:0] en0;
    logic [MAX_DW-1:0] en1;
  } qsrpi_wr_t;

  localparam int PINS_W = $bits(qsrpi_pins_t);
  localparam int WR_W = $bits(qsrpi_wr_t);

  ////////////////////////////////////////////////////////////////////////////////
  // Expands the active-low masks into one enable per data bit for a word width.
  function automatic logic [MAX_DW-1:0] qsrpi_lane_en(input int dw,
                                                      input logic [NIB_MASKS-1:0] nib_n,
                                                      input logic [BYTE_MASKS-1:0] byt_n);
    logic [MAX_DW-1:0] en;
    en = '0;
    for (int i = 0; i < MAX_DW; i++) begin
      if (i < dw) begin
        if (dw == DW_X8) begin
          en[i] = ~nib_n[i / NIB_W];
        end else begin
          en[i] = ~byt_n[i / LANE_W];
        end
      end
    end
    return en;
  endfunction

  // Rising edge of a sampled level against its previous sample.
  function automatic logic qsrpi_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

endpackage

// ### rtl/qsrpi_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins.
`timescale 1ns/1ps
module qsrpi_sync #(
  parameter int W = 8
) (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  if (W < 1) begin : g_bad_w
    $error("qsrpi_sync needs a width of at least one");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } qsrpi_sync_st_t;

  qsrpi_sync_st_t s_r;
  qsrpi_sync_st_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Only the second stage reads the first, so metastability never reaches logic.
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = d;
    s_nxt.sync = s_r.meta;
  end

  // Both stages freeze with the clock enable.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.sync;

endmodule

// ### rtl/qsrpi_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module qsrpi_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("qsrpi_fifo depth must be a power of two of at least two");
  end

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } qsrpi_fifo_st_t;

  qsrpi_fifo_st_t s_r;
  qsrpi_fifo_st_t s_nxt;
  logic [W-1:0] mem [0:DEPTH-1];
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////////
  // Full and empty come straight from the occupancy count.
  assign in_ready = (s_r.count != (PW + 1)'(DEPTH));
  assign out_valid = (s_r.count != '0);
  assign out_data = mem[s_r.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap naturally since the depth is a power of two.
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
    end
    s_nxt.count = s_r.count + (PW + 1)'(push) - (PW + 1)'(pop);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Storage has no reset; only written slots are ever read.
  always_ff @(posedge clock) begin
    if (ce && push) begin
      mem[s_r.wr_ptr] <= in_data;
    end
  end

endmodule

// ### rtl/qsrpi_top.sv
// Port interface of a separate-I/O double-data-rate two-word-burst SRAM.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - On the 8-bit width two active-low nibble masks travel with each data word, the first for bits 3:0 and the second for bits 7:4.
// - A nibble whose mask is deasserted is ignored and the stored nibble stays as it was.
// - On wider parts active-low byte masks travel with each data word, each covering a 9-bit lane from bit 0 upward.
// - A lane whose mask is deasserted is discarded and the stored lane stays as it was.
// - The shared address bus gives the read address at the positive input clock rise and the write address at the negative input clock rise.
// - Storage is two arrays, one per burst word, addressed by the low MEM_AW bits of the 21, 20 or 19-bit address.
// - The address is ignored for a port whose select is inactive on its sampling edge.
// - Read words leave on the rises of both output clocks, or of both input clocks in single-clock mode.
// - The read data outputs float once a positive launch edge finds no read pending.
// - An asserted read select at the positive input clock rise starts a read at the address of that edge.
// - After deselect the read in flight still completes and the drivers float after the next positive launch edge.
// - Every read returns exactly two sequential words from the addressed location.
// - Every access begins on a positive input clock rise, which also captures inputs and launches data in single-clock mode.
// - The negative input clock rise captures inputs too and launches the second word in single-clock mode.
// - An asserted write select at the positive input clock rise starts a write unless a burst is still held, and a deasserted one makes the data inputs ignored.
module qsrpi_top #(
  parameter int DATA_W = qsrpi_pkg::DW_X36,
  parameter int ADDR_W = qsrpi_pkg::AW_X36,
  parameter int MEM_AW = qsrpi_pkg::AW_X36
) (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Pins from the memory controller.
  input wire qsrpi_pkg::qsrpi_pins_t pins,
  // Read data pins, split into value and output enable.
  output logic [DATA_W-1:0] q_data,
  output logic q_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // Only the documented width and address pairings are served.
  localparam bit CFG_OK =
    ((DATA_W == qsrpi_pkg::DW_X8 || DATA_W == qsrpi_pkg::DW_X9) &&
     ADDR_W == qsrpi_pkg::AW_X8) ||
    (DATA_W == qsrpi_pkg::DW_X18 && ADDR_W == qsrpi_pkg::AW_X18) ||
    (DATA_W == qsrpi_pkg::DW_X36 && ADDR_W == qsrpi_pkg::AW_X36);
  localparam int MEM_DEPTH = 2 ** MEM_AW;

  if (!CFG_OK) begin : g_bad_cfg
    $error("qsrpi_top word width and address width do not pair");
  end
  if (MEM_AW < 1 || MEM_AW > ADDR_W) begin : g_bad_mem
    $error("qsrpi_top implemented array depth exceeds the address width");
  end

  typedef struct packed {
    logic prev_k;
    logic prev_kn;
    logic prev_c;
    logic prev_cn;
    logic rd_look;
    logic [qsrpi_pkg::MAX_AW-1:0] rd_addr;
    logic rd_pend;
    logic [qsrpi_pkg::MAX_DW-1:0] pend0;
    logic [qsrpi_pkg::MAX_DW-1:0] pend1;
    logic burst_half;
    logic [qsrpi_pkg::MAX_DW-1:0] word1;
    logic [qsrpi_pkg::MAX_DW-1:0] q;
    logic q_oe;
    logic wr_half;
    logic [qsrpi_pkg::MAX_DW-1:0] wr_d0;
    logic [qsrpi_pkg::MAX_DW-1:0] wr_en0;
    logic hold_v;
    qsrpi_pkg::qsrpi_wr_t hold;
  } qsrpi_top_st_t;

  qsrpi_top_st_t s_r;
  qsrpi_top_st_t s_nxt;
  qsrpi_pkg::qsrpi_pins_t ps;
  qsrpi_pkg::qsrpi_wr_t drain;
  logic [qsrpi_pkg::WR_W-1:0] drain_bits;
  logic drain_valid;
  logic drain_ready;
  logic fill_ready;
  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  logic lo_rise;
  logic lo_rise_n;
  logic [DATA_W-1:0] rd0;
  logic [DATA_W-1:0] rd1;
  logic [MEM_AW-1:0] wa;

  // One word of each burst in its own array.
  logic [DATA_W-1:0] mem0 [0:MEM_DEPTH-1];
  logic [DATA_W-1:0] mem1 [0:MEM_DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////////
  // Every pin, clocks included, passes the same two flops so data stays aligned to its edge.
  qsrpi_sync #(
    .W(qsrpi_pkg::PINS_W)
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .d(pins),
    .q(ps)
  );

  // Link clock edges as seen by our clock; a 400 ns link period gives eight samples.
  assign k_rise = qsrpi_pkg::qsrpi_rise(ps.k, s_r.prev_k);
  assign kn_rise = qsrpi_pkg::qsrpi_rise(ps.k_n, s_r.prev_kn);
  assign c_rise = qsrpi_pkg::qsrpi_rise(ps.c, s_r.prev_c);
  assign cn_rise = qsrpi_pkg::qsrpi_rise(ps.c_n, s_r.prev_cn);

  // Output launch edges follow the output clocks, or the input clocks in single-clock mode.
  assign lo_rise = ps.single_clk_mode ? k_rise : c_rise;
  assign lo_rise_n = ps.single_clk_mode ? kn_rise : cn_rise;

  ////////////////////////////////////////////////////////////////////////////////
  // Array lookup for the captured read address, both burst words at once.
  assign rd0 = mem0[s_r.rd_addr[MEM_AW-1:0]];
  assign rd1 = mem1[s_r.rd_addr[MEM_AW-1:0]];

  // The arrays have one port; the drain waits while a read lookup owns them.
  assign drain_ready = !s_r.rd_look;
  assign drain = drain_bits;
  assign wa = drain.addr[MEM_AW-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Completed write bursts queue here so array access never blocks pin capture.
  qsrpi_fifo #(
    .W(qsrpi_pkg::WR_W),
    .DEPTH(qsrpi_pkg::WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .in_valid(s_r.hold_v),
    .in_ready(fill_ready),
    .in_data(s_r.hold),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_bits)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for edge tracking, the read pipe, the output stage and write capture.
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev_k = ps.k;
    s_nxt.prev_kn = ps.k_n;
    s_nxt.prev_c = ps.c;
    s_nxt.prev_cn = ps.c_n;

    // A finished lookup parks both words until the next launch edge.
    if (s_r.rd_look) begin
      s_nxt.rd_pend = 1'b1;
      s_nxt.pend0 = '0;
      s_nxt.pend1 = '0;
      s_nxt.pend0[DATA_W-1:0] = rd0;
      s_nxt.pend1[DATA_W-1:0] = rd1;
    end

    // First word on the positive launch edge; no pending read means the drivers let go.
    if (lo_rise) begin
      if (s_r.rd_pend) begin
        s_nxt.q = s_r.pend0;
        s_nxt.word1 = s_r.pend1;
        s_nxt.burst_half = 1'b1;
        s_nxt.q_oe = 1'b1;
        s_nxt.rd_pend = s_r.rd_look;
      end else begin
        s_nxt.burst_half = 1'b0;
        s_nxt.q_oe = 1'b0;
      end
    end

    // Second word on the negative launch edge closes the two-word burst.
    if (lo_rise_n && s_r.burst_half) begin
      s_nxt.q = s_r.word1;
      s_nxt.burst_half = 1'b0;
    end

    // Read select and address are looked at only on the positive input rise.
    s_nxt.rd_look = 1'b0;
    if (k_rise && !ps.read_port_sel_n) begin
      s_nxt.rd_look = 1'b1;
      s_nxt.rd_addr = '0;
      s_nxt.rd_addr[ADDR_W-1:0] = ps.addr[ADDR_W-1:0];
    end

    // The FIFO takes the held burst; clearing first lets a new burst land this cycle.
    if (s_r.hold_v && fill_ready) begin
      s_nxt.hold_v = 1'b0;
    end

    // Write select opens a burst with word one; while a burst is still held it is refused.
    if (k_rise) begin
      if (!ps.write_port_sel_n && !s_nxt.hold_v) begin
        s_nxt.wr_half = 1'b1;
        s_nxt.wr_d0 = ps.data;
        s_nxt.wr_en0 = qsrpi_pkg::qsrpi_lane_en(DATA_W, ps.nibble_wr_mask_n,
                                                ps.byte_wr_mask_n);
      end else begin
        s_nxt.wr_half = 1'b0;
      end
    end

    // Negative input rise brings the write address, word two and its masks.
    if (kn_rise && s_r.wr_half) begin
      s_nxt.wr_half = 1'b0;
      s_nxt.hold_v = 1'b1;
      s_nxt.hold.addr = '0;
      s_nxt.hold.addr[ADDR_W-1:0] = ps.addr[ADDR_W-1:0];
      s_nxt.hold.d0 = s_r.wr_d0;
      s_nxt.hold.en0 = s_r.wr_en0;
      s_nxt.hold.d1 = ps.data;
      s_nxt.hold.en1 = qsrpi_pkg::qsrpi_lane_en(DATA_W, ps.nibble_wr_mask_n,
                                                ps.byte_wr_mask_n);
    end
  end

  // All control state freezes with the enable and clears on reset.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit-level merge: a bit without its enable keeps its stored value.
  always_ff @(posedge clock) begin
    if (ce && drain_valid && drain_ready) begin
      for (int i = 0; i < DATA_W; i++) begin
        if (drain.en0[i]) begin
          mem0[wa][i] <= drain.d0[i];
        end
        if (drain.en1[i]) begin
          mem1[wa][i] <= drain.d1[i];
        end
      end
    end
  end

  // Pin drivers come straight from flops.
  assign q_data = s_r.q[DATA_W-1:0];
  assign q_oe = s_r.q_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the read path.
  a_rd_start_look: assert property (@(posedge clock) disable iff (rst)
    ce && k_rise && !ps.read_port_sel_n |=> s_r.rd_look &&
      s_r.rd_addr[ADDR_W-1:0] == $past(ps.addr[ADDR_W-1:0]))
    else $error("read select did not start a lookup at the sampled address");

  a_rd_deselect_ignore: assert property (@(posedge clock) disable iff (rst)
    ce && k_rise && ps.read_port_sel_n |=> !s_r.rd_look)
    else $error("deselected read port still started a lookup");

  a_rd_pend_words: assert property (@(posedge clock) disable iff (rst)
    ce && s_r.rd_look |=> s_r.rd_pend && s_r.pend0[DATA_W-1:0] == $past(rd0) &&
      s_r.pend1[DATA_W-1:0] == $past(rd1))
    else $error("lookup did not park both array words");

  a_out_first_word: assert property (@(posedge clock) disable iff (rst)
    ce && lo_rise && s_r.rd_pend |=> q_oe && q_data == $past(s_r.pend0[DATA_W-1:0]))
    else $error("first burst word not driven on launch edge");

  a_out_second_word: assert property (@(posedge clock) disable iff (rst)
    ce && lo_rise_n && s_r.burst_half |=> q_oe && !s_r.burst_half &&
      q_data == $past(s_r.word1[DATA_W-1:0]))
    else $error("second burst word not driven on negative launch edge");

  a_out_float_idle: assert property (@(posedge clock) disable iff (rst)
    ce && lo_rise && !s_r.rd_pend |=> !q_oe)
    else $error("drivers did not float after launch edge with no read");

  a_oe_edge_only: assert property (@(posedge clock) disable iff (rst)
    !(ce && lo_rise) |=> $stable(q_oe))
    else $error("output enable changed away from a launch edge");

  // Checks on the write path.
  a_wr_first_half: assert property (@(posedge clock) disable iff (rst)
    ce && k_rise && !ps.write_port_sel_n && !s_r.hold_v |=> s_r.wr_half &&
      s_r.wr_d0 == $past(ps.data))
    else $error("write select did not capture word one");

  a_wr_deselect: assert property (@(posedge clock) disable iff (rst)
    ce && k_rise && ps.write_port_sel_n |=> !s_r.wr_half)
    else $error("deselected write port still opened a burst");

  a_wr_second_half: assert property (@(posedge clock) disable iff (rst)
    ce && kn_rise && s_r.wr_half |=> s_r.hold_v && !s_r.wr_half &&
      s_r.hold.addr[ADDR_W-1:0] == $past(ps.addr[ADDR_W-1:0]))
    else $error("negative rise did not complete the write burst");

  a_mask_keep_bits: assert property (@(posedge clock) disable iff (rst)
    ce && drain_valid && drain_ready |=>
      (mem0[$past(wa)] & ~$past(drain.en0[DATA_W-1:0])) ==
      ($past(mem0[wa]) & ~$past(drain.en0[DATA_W-1:0])))
    else $error("masked bits of a stored word changed");

  a_wr_lane_zero: assert property (@(posedge clock) disable iff (rst)
    ce && k_rise && !ps.write_port_sel_n && !s_r.hold_v |=>
      s_r.wr_en0[0] == !(DATA_W == qsrpi_pkg::DW_X8 ?
      $past(ps.nibble_wr_mask_n[0]) : $past(ps.byte_wr_mask_n[0])))
    else $error("first mask did not govern bit zero of word one");

  a_wr_word_two: assert property (@(posedge clock) disable iff (rst)
    ce && kn_rise && s_r.wr_half |=> s_r.hold.d1 == $past(ps.data) &&
      s_r.hold.d0 == $past(s_r.wr_d0))
    else $error("negative rise did not capture word two");

  a_kn_no_open: assert property (@(posedge clock) disable iff (rst)
    ce && kn_rise && !s_r.wr_half && !s_r.hold_v |=> !s_r.hold_v)
    else $error("negative rise without an open write queued a burst");

  // Output data may only move on a launch edge, so a stray edge would show here.
  a_q_launch_only: assert property (@(posedge clock) disable iff (rst)
    !(ce && (lo_rise || lo_rise_n)) |=> $stable(q_data))
    else $error("read data changed away from a launch edge");

  // A low enable must freeze every control flop, the edge trackers included.
  a_ce_freeze: assert property (@(posedge clock) disable iff (rst)
    !ce |=> s_r == $past(s_r))
    else $error("state moved while the clock enable was low");

  // Main scenarios.
  c_read_burst: cover property (@(posedge clock) disable iff (rst)
    ce && lo_rise && s_r.rd_pend ##[1:16] ce && lo_rise_n && s_r.burst_half);
  c_write_commit: cover property (@(posedge clock) disable iff (rst)
    ce && drain_valid && drain_ready);
  c_back_to_back: cover property (@(posedge clock) disable iff (rst)
    ce && lo_rise && s_r.rd_pend && s_r.rd_look);
  c_float_after: cover property (@(posedge clock) disable iff (rst)
    $fell(q_oe));
  c_ce_hold: cover property (@(posedge clock) disable iff (rst)
    !ce ##1 !ce);

endmodule

// ### verification/qsrpi_ctl_model.sv
// Memory-controller model that drives every pin of the burst SRAM port interface.
`timescale 1ns/1ps
module qsrpi_ctl_model (
  // Pacing clock.
  input wire logic clock,
  // Pins toward the memory.
  output qsrpi_pkg::qsrpi_pins_t pins
);
  // Idle pins: link clocks still, both ports deselected, every lane masked.
  initial begin
    pins = '0;
    pins.read_port_sel_n = 1'b1;
    pins.write_port_sel_n = 1'b1;
    pins.nibble_wr_mask_n = '1;
    pins.byte_wr_mask_n = '1;
  end

  // One link period of eight system cycles; the link clocks stand still between calls.
  // Unused address and data buses carry the inverse of their last value so stale data never looks valid.
  task automatic period(input logic single, input logic rd, input logic wr,
                        input logic [18:0] ra, input logic [18:0] wa,
                        input logic [35:0] d0, input logic [35:0] d1,
                        input logic [3:0] m0, input logic [3:0] m1);
    @(posedge clock);
    pins.single_clk_mode <= single;
    pins.k <= 1'b1;
    pins.k_n <= 1'b0;
    pins.c <= !single;
    pins.c_n <= 1'b0;
    pins.read_port_sel_n <= !rd;
    pins.write_port_sel_n <= !wr;
    pins.addr <= rd ? {2'b00, ra} : ~pins.addr;
    pins.data <= wr ? d0 : ~pins.data;
    pins.byte_wr_mask_n <= m0;
    pins.nibble_wr_mask_n <= m0[1:0];
    repeat (4) @(posedge clock);
    pins.k <= 1'b0;
    pins.k_n <= 1'b1;
    pins.c <= 1'b0;
    pins.c_n <= !single;
    pins.read_port_sel_n <= 1'b1;
    pins.write_port_sel_n <= 1'b1;
    pins.addr <= wr ? {2'b00, wa} : ~pins.addr;
    pins.data <= wr ? d1 : ~pins.data;
    pins.byte_wr_mask_n <= m1;
    pins.nibble_wr_mask_n <= m1[1:0];
    repeat (3) @(posedge clock);
  endtask
endmodule

// ### verification/tb.sv
// Self-checking bench of the burst SRAM port interface, its write queue reached through the top.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin err_count++; \
  $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module tb;
  logic clock;
  logic rst;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed;
  qsrpi_pkg::qsrpi_pins_t pins;
  logic [35:0] q_data;
  logic q_oe;
  logic [35:0] mem0 [16];
  logic [35:0] mem1 [16];
  logic [35:0] exp_q [$];
  logic ce;

  ////////////////////////////////////////////////////////////////////////////////
  // A small array keeps the fill short; upper address bits alias.
  qsrpi_top #(.DATA_W(qsrpi_pkg::DW_X36), .ADDR_W(qsrpi_pkg::AW_X36), .MEM_AW(4)) dut_u (
    .clock(clock), .rst(rst), .ce(ce), .pins(pins), .q_data(q_data), .q_oe(q_oe));
  qsrpi_ctl_model ctl_u (.clock(clock), .pins(pins));

  // Clock and hang guard.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      results();
    end
  end

  // Verdict and end of run.
  task automatic results;
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Each link edge may launch one word; look once synchroniser and output register settle.
  task automatic look;
    logic [35:0] e;
    repeat (6) @(negedge clock);
    if (q_oe === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `CHK("q_data", e, q_data)
    end else begin
      `CHK("q_oe", 1'b0, q_oe)
    end
  endtask
  always @(posedge pins.k) look();
  always @(posedge pins.k_n) look();

  // Merge a burst word into the reference image; masked lanes keep their old bits.
  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d,
                                        input logic [3:0] m);
    for (int i = 0; i < 36; i++) begin
      if (m[i / 9] == 1'b0) old[i] = d[i];
    end
    return old;
  endfunction

  // One link period; the read burst is noted before a write of the same period lands.
  task automatic op(input logic single, input logic rd, input logic wr, input logic full,
                    input logic [3:0] fa);
    logic [18:0] ra;
    logic [18:0] wa;
    logic [35:0] d0;
    logic [35:0] d1;
    logic [3:0] m0;
    logic [3:0] m1;
    ra = full ? {15'($random(seed)), fa} : 19'($random(seed));
    wa = full ? {15'($random(seed)), fa} : 19'($random(seed));
    d0 = 36'({$random(seed), $random(seed)});
    d1 = 36'({$random(seed), $random(seed)});
    m0 = full ? 4'h0 : 4'($random(seed));
    m1 = full ? 4'h0 : 4'($random(seed));
    if (rd) begin
      exp_q.push_back(mem0[ra[3:0]]);
      exp_q.push_back(mem1[ra[3:0]]);
    end
    if (wr) begin
      mem0[wa[3:0]] = merge(mem0[wa[3:0]], d0, m0);
      mem1[wa[3:0]] = merge(mem1[wa[3:0]], d1, m1);
    end
    ctl_u.period(single, rd, wr, ra, wa, d0, d1, m0, m1);
  endtask

  // A low enable must hold the idle outputs; then one location is written, rewritten
  // while being read, and read again, so the write queue's order shows at the pins.
  task automatic order_test;
    ce <= 1'b0;
    repeat (4) @(negedge clock);
    `CHK("frozen_oe", 1'b0, q_oe)
    `CHK("frozen_q", 36'h0_0000_0000, q_data)
    @(posedge clock);
    ce <= 1'b1;
    op(1'b0, 1'b0, 1'b1, 1'b1, 4'h5);
    op(1'b0, 1'b1, 1'b1, 1'b1, 4'h5);
    op(1'b0, 1'b1, 1'b0, 1'b1, 4'h5);
    repeat (2) op(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    `CHK("order_left", 0, exp_q.size())
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Both launch modes: full-mask fill, then random concurrent traffic, then flush.
  initial begin
    seed = 33;
    rst = 1'b1;
    ce = 1'b1;
    repeat (3) @(negedge clock);
    `CHK("reset_oe", 1'b0, q_oe)
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    order_test();
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 16; a++) op(s[0], 1'b0, 1'b1, 1'b1, 4'(a));
      for (int n = 0; n < 40; n++) op(s[0], 1'($random(seed)), 1'($random(seed)), 1'b0, 4'h0);
      repeat (3) op(s[0], 1'b0, 1'b0, 1'b0, 4'h0);
    end
    `CHK("pending", 0, exp_q.size())
    results();
  end
endmodule
